// [src/ssw_map.vh]
// register map, field positions, reset values and timing counts of the supervisor
`ifndef SSW_MAP_VH
`define SSW_MAP_VH

// register indices; byte address is four times the index
`define SSW_IDX_CLK_PERIOD 8'h8e
`define SSW_IDX_XFLAG 8'h91
`define SSW_IDX_UNLOCK 8'hc7
`define SSW_IDX_DOG_CTRL 8'hd8
`define SSW_IDX_XIRQ_EN 8'he8
`define SSW_IDX_INTERNAL_ROM_SIZE_REG 8'hf1
`define SSW_IDX_PRIO_LO 8'hf2
`define SSW_IDX_PRIO_HI 8'hf3

// watchdog_supply_control fields
`define SSW_DC_POR_FLAG 6
`define SSW_DC_WARN_EN 5
`define SSW_DC_WARN_FLAG 4
`define SSW_DC_DOG_IRQF 3
`define SSW_DC_DOG_TOF 2
`define SSW_DC_DOG_RSTEN 1
`define SSW_DC_DOG_RESTART 0
// clock_and_period_control fields
`define SSW_CP_PSEL_HI 7
`define SSW_CP_PSEL_LO 6
// extended_irq_enable and extended_flag_reg fields
`define SSW_XE_DOG_IRQEN 4
`define SSW_XF_BANDGAP 0

// reset values
`define SSW_RST_CLK_PERIOD 8'h00
`define SSW_RST_XIRQ_EN 8'h00
`define SSW_RST_XFLAG 8'h00
`define SSW_RST_INTERNAL_ROM_SIZE_REG 3'h0
`define SSW_RST_PRIO 8'h00

// unlock sequence
`define SSW_UNLOCK_FIRST 8'haa
`define SSW_UNLOCK_SECOND 8'h55
`define SSW_UNLOCK_WIN_MC 3
`define SSW_CLKS_PER_MC 4

// timing counts in crystal clocks
`define SSW_POR_CLKS 65536
`define SSW_DOG_GAP_CLKS 512
`define SSW_DOG_P0_CLKS 131072
`define SSW_DOG_P1_CLKS 1048576
`define SSW_DOG_P2_CLKS 8388608
`define SSW_DOG_P3_CLKS 67108864
`define SSW_DOG_RST_CLKS 4

// interrupt table
`define SSW_NSRC 13
`define SSW_VEC_WARN 8'h33
`define SSW_VEC_CLASSIC 8'h03
`define SSW_VEC_SERIAL1 8'h3b
`define SSW_VEC_NEW 8'h43

`endif

// [src/ssw_irq_prio.v]
// interrupt priority resolver: fixed top source, two levels, natural order for ties
`timescale 1ns/10ps
`default_nettype none
`include "ssw_map.vh"

module ssw_irq_prio #(
   parameter N = `SSW_NSRC
) (
   input wire [N-1:0] req,
   input wire [N-1:0] high,
   output reg valid,
   output reg is_high,
   output reg [7:0] vector
);

   // index 0 is the supply warning, 1..6 classic, 7 second serial port, 8..12 newer sources;
   // the second serial port skips 33h because the warning owns that vector
   function [7:0] vec_of;
      input [3:0] i;
      begin
         if (i == 4'd0)
            vec_of = `SSW_VEC_WARN;
         else if (i < 4'd7)
            vec_of = `SSW_VEC_CLASSIC + {1'b0, i - 4'd1, 3'b000};
         else if (i == 4'd7)
            vec_of = `SSW_VEC_SERIAL1;
         else
            vec_of = `SSW_VEC_NEW + {1'b0, i - 4'd8, 3'b000};
      end
   endfunction

   integer k;
   reg [3:0] hi_idx;
   reg [3:0] lo_idx;
   reg hi_any;
   reg lo_any;

   always @* begin
      hi_idx = 4'd0;
      lo_idx = 4'd0;
      hi_any = 1'b0;
      lo_any = 1'b0;
      // scan downward so the lowest index, the highest natural priority, wins
      for (k = N - 1; k >= 0; k = k - 1) begin
         if (req[k] && (high[k] || k == 0)) begin
            hi_idx = k[3:0];
            hi_any = 1'b1;
         end
         if (req[k]) begin
            lo_idx = k[3:0];
            lo_any = 1'b1;
         end
      end
      valid = hi_any | lo_any;
      is_high = hi_any;
      vector = hi_any ? vec_of(hi_idx) : (lo_any ? vec_of(lo_idx) : 8'h00);
   end

endmodule // ssw_irq_prio

`default_nettype wire

// [src/ssw_top.v]
// supply supervisor: power-on/brownout reset, supply warning, watchdog, unlock, irq table
`timescale 1ns/10ps
`default_nettype none
`include "ssw_map.vh"

module ssw_top #(
   parameter POR_CLKS = `SSW_POR_CLKS,
   parameter GAP_CLKS = `SSW_DOG_GAP_CLKS,
   parameter P0_CLKS = `SSW_DOG_P0_CLKS,
   parameter P1_CLKS = `SSW_DOG_P1_CLKS,
   parameter P2_CLKS = `SSW_DOG_P2_CLKS,
   parameter P3_CLKS = `SSW_DOG_P3_CLKS
) (
   input wire sys_clk,
   input wire nrst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [9:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output wire wb_ack_o,
   input wire supply_below_rst,
   input wire supply_below_warn,
   input wire [10:0] ext_irq_req,
   output reg cpu_rst,
   output reg osc_enable,
   output reg irq_valid,
   output reg irq_high,
   output reg [7:0] irq_vector,
   output reg wake_req,
   output wire bandgap_select,
   output wire [2:0] romsel
);

   localparam ST_HOLD = 2'd0;
   localparam ST_COUNT = 2'd1;
   localparam ST_RUN = 2'd2;
   localparam [3:0] WIN_CLKS = `SSW_UNLOCK_WIN_MC * `SSW_CLKS_PER_MC;
   localparam [2:0] WDR_CLKS = `SSW_DOG_RST_CLKS;
   localparam [16:0] POR_LAST = POR_CLKS[16:0] - 17'd1;

   // comparator pins cross into the crystal domain
   reg low_s1_q, low_s2_q, warn_s1_q, warn_s2_q;
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         low_s1_q <= 1'b1;
         low_s2_q <= 1'b1;
         warn_s1_q <= 1'b0;
         warn_s2_q <= 1'b0;
      end else begin
         low_s1_q <= supply_below_rst;
         low_s2_q <= low_s1_q;
         warn_s1_q <= supply_below_warn;
         warn_s2_q <= warn_s1_q;
      end
   end

   // wishbone slave: ack one cycle after the strobe, write lands on the ack edge
   reg ack_q;
   wire bus_req = wb_cyc_i & wb_stb_i;
   wire [7:0] idx = wb_adr_i[9:2];
   wire [7:0] wdat = wb_dat_i[7:0];
   wire wr_go = bus_req & ack_q & wb_we_i & wb_sel_i[0];
   assign wb_ack_o = ack_q;

   function wr_at;
      input go;
      input [7:0] a;
      input [7:0] want;
      begin
         wr_at = go && (a == want);
      end
   endfunction

   wire wr_clkp = wr_at(wr_go, idx, `SSW_IDX_CLK_PERIOD);
   wire wr_xflag = wr_at(wr_go, idx, `SSW_IDX_XFLAG);
   wire wr_unlock = wr_at(wr_go, idx, `SSW_IDX_UNLOCK);
   wire wr_dogc = wr_at(wr_go, idx, `SSW_IDX_DOG_CTRL);
   wire wr_xien = wr_at(wr_go, idx, `SSW_IDX_XIRQ_EN);
   wire wr_roms = wr_at(wr_go, idx, `SSW_IDX_INTERNAL_ROM_SIZE_REG);
   wire wr_prlo = wr_at(wr_go, idx, `SSW_IDX_PRIO_LO);
   wire wr_prhi = wr_at(wr_go, idx, `SSW_IDX_PRIO_HI);

   // unlock sequence and write window
   reg stage_q;
   reg [3:0] win_q;
   wire win_open = (win_q != 4'h0);
   wire prot_wr = wr_xflag | wr_dogc | wr_roms;

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stage_q <= 1'b0;
         win_q <= 4'h0;
      end else if (wr_unlock) begin
         if (wdat == `SSW_UNLOCK_FIRST) begin
            stage_q <= 1'b1;
            win_q <= 4'h0;
         end else if (stage_q && wdat == `SSW_UNLOCK_SECOND) begin
            stage_q <= 1'b0;
            win_q <= WIN_CLKS;
         end else begin
            stage_q <= 1'b0;
            win_q <= 4'h0;
         end
      end else begin
         // any other write cancels a half-done pair; the window stays open until a protected write or until its count runs out
         if (wr_go)
            stage_q <= 1'b0;
         if (prot_wr)
            win_q <= 4'h0;
         else if (win_open)
            win_q <= win_q - 4'h1;
      end
   end

   wire ok_dogc = wr_dogc & win_open;
   wire ok_xflag = wr_xflag & win_open;
   wire ok_roms = wr_roms & win_open;

   // plain registers
   reg [7:0] clkp_q, xien_q, prlo_q, prhi_q;
   reg [7:1] xflag_q;
   reg bgs_q;
   reg [2:0] roms_q;
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         clkp_q <= `SSW_RST_CLK_PERIOD;
         xien_q <= `SSW_RST_XIRQ_EN;
         prlo_q <= `SSW_RST_PRIO;
         prhi_q <= `SSW_RST_PRIO;
         xflag_q <= 7'h00;
         bgs_q <= 1'b0;
         roms_q <= `SSW_RST_INTERNAL_ROM_SIZE_REG;
      end else begin
         if (wr_clkp)
            clkp_q <= wdat;
         if (wr_xien)
            xien_q <= wdat;
         if (wr_prlo)
            prlo_q <= wdat;
         if (wr_prhi)
            prhi_q <= {4'h0, wdat[3:0]};
         if (wr_xflag)
            xflag_q <= wdat[7:1];
         if (ok_xflag)
            bgs_q <= wdat[`SSW_XF_BANDGAP];
         if (ok_roms)
            roms_q <= wdat[2:0];
      end
   end
   assign bandgap_select = bgs_q;
   assign romsel = roms_q;

   // power-on / brownout sequencer
   reg [1:0] st_q, st_d;
   reg [16:0] por_cnt_q;
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_HOLD: if (!low_s2_q) st_d = ST_COUNT;
         ST_COUNT: if (por_cnt_q == POR_LAST) st_d = ST_RUN;
         ST_RUN: st_d = ST_RUN;
         default: st_d = ST_HOLD;
      endcase
      if (low_s2_q)
         st_d = ST_HOLD;
   end
   wire run = (st_q == ST_RUN);
   wire por_done = (st_q == ST_COUNT) && (st_d == ST_RUN);

   // watchdog counter, straight off the crystal clock
   reg [26:0] wd_cnt_q;
   wire [1:0] psel = {clkp_q[`SSW_CP_PSEL_HI], clkp_q[`SSW_CP_PSEL_LO]};

   function [26:0] period_of;
      input [1:0] s;
      begin
         case (s)
            2'd0: period_of = P0_CLKS[26:0];
            2'd1: period_of = P1_CLKS[26:0];
            2'd2: period_of = P2_CLKS[26:0];
            default: period_of = P3_CLKS[26:0];
         endcase
      end
   endfunction

   wire [26:0] int_last = period_of(psel) - 27'd1;
   wire [26:0] full_last = period_of(psel) + GAP_CLKS[26:0] - 27'd1;
   wire int_hit = run && (wd_cnt_q == int_last);
   wire full_hit = run && (wd_cnt_q == full_last);
   wire restart = ok_dogc & wdat[`SSW_DC_DOG_RESTART];

   // control / status flags; a hardware set beats a software clear
   reg por_f_q, warn_en_q, warn_f_q, irqf_q, tof_q, rsten_q;
   reg [2:0] wdr_q;
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_HOLD;
         por_cnt_q <= 17'h00000;
         wd_cnt_q <= 27'h0000000;
         por_f_q <= 1'b0;
         warn_en_q <= 1'b0;
         warn_f_q <= 1'b0;
         irqf_q <= 1'b0;
         tof_q <= 1'b0;
         rsten_q <= 1'b0;
         wdr_q <= 3'h0;
      end else begin
         st_q <= st_d;
         if (st_q == ST_COUNT)
            por_cnt_q <= por_cnt_q + 17'h00001;
         else
            por_cnt_q <= 17'h00000;
         // a full timeout wraps the count so the flag also serves as a time base
         if (!run || restart || full_hit)
            wd_cnt_q <= 27'h0000000;
         else
            wd_cnt_q <= wd_cnt_q + 27'h0000001;
         if (por_done)
            por_f_q <= 1'b1;
         else if (ok_dogc)
            por_f_q <= wdat[`SSW_DC_POR_FLAG];
         if (wr_dogc)
            warn_en_q <= wdat[`SSW_DC_WARN_EN];
         if (warn_s2_q)
            warn_f_q <= 1'b1;
         else if (wr_dogc)
            warn_f_q <= wdat[`SSW_DC_WARN_FLAG];
         if (int_hit)
            irqf_q <= 1'b1;
         else if (ok_dogc)
            irqf_q <= wdat[`SSW_DC_DOG_IRQF];
         if (full_hit)
            tof_q <= 1'b1;
         else if (wr_dogc)
            tof_q <= wdat[`SSW_DC_DOG_TOF];
         if (ok_dogc)
            rsten_q <= wdat[`SSW_DC_DOG_RSTEN];
         if (full_hit && rsten_q)
            wdr_q <= WDR_CLKS;
         else if (wdr_q != 3'h0)
            wdr_q <= wdr_q - 3'h1;
      end
   end

   // reset and oscillator outputs
   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cpu_rst <= 1'b1;
         osc_enable <= 1'b0;
      end else begin
         cpu_rst <= (st_d != ST_RUN) || (full_hit && rsten_q) || (wdr_q > 3'h1);
         osc_enable <= (st_d != ST_HOLD);
      end
   end

   // interrupt table
   wire warn_req = warn_f_q & warn_en_q;
   wire dog_req = irqf_q & xien_q[`SSW_XE_DOG_IRQEN];
   wire [12:0] src_req = {dog_req, ext_irq_req, warn_req};
   wire [12:0] src_high = {prhi_q[3:0], prlo_q, 1'b1};
   wire pr_valid, pr_high;
   wire [7:0] pr_vec;

   ssw_irq_prio #(
      .N(`SSW_NSRC)
   ) u_prio (
      .req(src_req),
      .high(src_high),
      .valid(pr_valid),
      .is_high(pr_high),
      .vector(pr_vec)
   );

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_valid <= 1'b0;
         irq_high <= 1'b0;
         irq_vector <= 8'h00;
         wake_req <= 1'b0;
      end else begin
         irq_valid <= pr_valid;
         irq_high <= pr_high;
         irq_vector <= pr_vec;
         wake_req <= dog_req | warn_req;
      end
   end

   // read mux; the restart bit always reads zero
   reg [7:0] rd_mux;
   always @* begin
      case (idx)
         `SSW_IDX_CLK_PERIOD: rd_mux = clkp_q;
         `SSW_IDX_XFLAG: rd_mux = {xflag_q, bgs_q};
         `SSW_IDX_DOG_CTRL: rd_mux = {1'b0, por_f_q, warn_en_q, warn_f_q,
                                      irqf_q, tof_q, rsten_q, 1'b0};
         `SSW_IDX_XIRQ_EN: rd_mux = xien_q;
         `SSW_IDX_INTERNAL_ROM_SIZE_REG: rd_mux = {5'h00, roms_q};
         `SSW_IDX_PRIO_LO: rd_mux = prlo_q;
         `SSW_IDX_PRIO_HI: rd_mux = prhi_q;
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack_q <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         ack_q <= bus_req & ~ack_q;
         if (bus_req && !ack_q)
            wb_dat_o <= {24'h000000, rd_mux};
      end
   end

endmodule // ssw_top

`default_nettype wire

// [tb/ssw_top_properties.sv]
// port-level checker of the supply supervisor
`timescale 1ns/10ps
`default_nettype none
module ssw_props #(
   parameter GAP_CLKS = 512
) (
   input wire sys_clk,
   input wire nrst,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire supply_below_rst,
   input wire cpu_rst,
   input wire osc_enable,
   input wire irq_valid,
   input wire irq_high,
   input wire [7:0] irq_vector,
   input wire wake_req
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) && wb_dat_o[31:8] == 0)
      else $error("ack without request or upper data set");
   brown_hold_a: assert property (supply_below_rst [*3] |=> cpu_rst && !osc_enable)
      else $error("low supply did not hold reset");
   // bench runs the start-up count at 16 clocks
   por_count_a: assert property ($rose(osc_enable) |-> cpu_rst ##15 cpu_rst ##1 !cpu_rst)
      else $error("start-up count wrong");
   dog_pulse_a: assert property ($rose(cpu_rst) && osc_enable && !supply_below_rst
      |-> cpu_rst [*4] ##1 !cpu_rst) else $error("watchdog reset pulse wrong");
   // the vector must appear exactly one cycle short of the gap before the reset, not earlier
   dog_gap_a: assert property ($rose(cpu_rst) && osc_enable && irq_vector == 8'h63
      |-> $past(irq_vector, GAP_CLKS - 1) == 8'h63 && $past(irq_vector, GAP_CLKS) != 8'h63)
      else $error("irq to reset gap wrong");
   warn_top_a: assert property (irq_vector == 8'h33 |-> irq_high && irq_valid && wake_req)
      else $error("warning vector not top or no wake");
   dog_wake_a: assert property (irq_vector == 8'h63 |-> wake_req && irq_valid)
      else $error("watchdog irq without wake request");
   idle_vec_a: assert property (!irq_valid |-> irq_vector == 8'h00)
      else $error("vector shown with no request");
   cover property ($rose(cpu_rst) && osc_enable);
   cover property (irq_vector == 8'h33);
   cover property (irq_vector == 8'h63);
endmodule // ssw_props

bind ssw_top ssw_props #(.GAP_CLKS(GAP_CLKS)) u_props (.sys_clk(sys_clk), .nrst(nrst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .supply_below_rst(supply_below_rst), .cpu_rst(cpu_rst), .osc_enable(osc_enable),
   .irq_valid(irq_valid), .irq_high(irq_high), .irq_vector(irq_vector), .wake_req(wake_req));
`default_nettype wire

// [tb/test_ssw_top.sv]
// self-checking bench of the supply supervisor
`timescale 1ns/10ps
`default_nettype none
module test_ssw_top;
   localparam int GAP = 8;
   logic sys_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic brst = 1'b0, bwarn = 1'b0;
   logic [3:0] sel = 4'h0, lane = 4'h1;
   logic ack, cpu_rst, osc_en, ivalid, ihigh, wake, bg;
   logic [9:0] adr = 10'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] dat_o;
   logic [10:0] ext = 11'h0;
   logic [7:0] vec;
   logic [2:0] romsel;
   int failures = 0, n_tests = 0, cycles = 0, n;

   ssw_top #(.POR_CLKS(16), .GAP_CLKS(GAP), .P0_CLKS(32), .P1_CLKS(64), .P2_CLKS(128),
      .P3_CLKS(256)) dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .supply_below_rst(brst), .supply_below_warn(bwarn), .ext_irq_req(ext),
      .cpu_rst(cpu_rst), .osc_enable(osc_en), .irq_valid(ivalid), .irq_high(ihigh),
      .irq_vector(vec), .wake_req(wake), .bandgap_select(bg), .romsel(romsel));

   always #10 sys_clk = ~sys_clk;

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // the run is under two thousand cycles; a hang is cut off well beyond that
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         failures++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // outputs are read right after an edge, so they show what the previous edge set
   task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d,
      output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lane;
      adr <= {i, 2'b00};
      dat <= {24'h0, d};
      do @(posedge sys_clk); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, i, d, q);
   endtask

   task automatic rd(input logic [7:0] i, input logic [7:0] m, input logic [7:0] e,
      input string nm);
      logic [31:0] q;
      bus(1'b0, i, 8'h00, q);
      chk(q & {24'hffffff, m}, {24'h0, e}, nm);
   endtask

   task automatic unlock();
      wr(8'hc7, 8'haa);
      wr(8'hc7, 8'h55);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   // 0: cpu reset low, 1: watchdog vector, 2: cpu reset high
   task automatic count(input int w, output int k);
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (k < 1000 && (w == 0 ? cpu_rst !== 1'b0 :
         w == 1 ? vec !== 8'h63 : cpu_rst !== 1'b1));
   endtask

   initial begin
      tick(6);
      chk(cpu_rst, 1'b1, "cpu reset in reset");
      chk(osc_en, 1'b0, "oscillator in reset");
      nrst <= 1'b1;
      count(0, n);
      chk(n, 20, "start-up count");
      rd(8'h8e, 8'hff, 8'h00, "period reg reset");
      rd(8'he8, 8'hff, 8'h00, "irq enable reset");
      rd(8'h91, 8'hff, 8'h00, "flag reg reset");
      rd(8'hd8, 8'hf3, 8'h40, "dog control reset");
      rd(8'hc7, 8'hff, 8'h00, "unlock reads zero");
      wr(8'h10, 8'hff);
      rd(8'h10, 8'hff, 8'h00, "unmapped");
      // a write without lane zero selected must not land
      lane = 4'he;
      wr(8'h8e, 8'hc0);
      lane = 4'h1;
      rd(8'h8e, 8'hff, 8'h00, "lane zero off");
      $display("test reset done");
      wr(8'hd8, 8'h22);
      rd(8'hd8, 8'hf3, 8'h60, "locked write");
      unlock();
      wr(8'hd8, 8'h22);
      rd(8'hd8, 8'hf3, 8'h22, "unlocked write");
      wr(8'hd8, 8'h20);
      rd(8'hd8, 8'hf3, 8'h22, "window closed");
      unlock();
      wr(8'hd8, 8'h60);
      wr(8'hc7, 8'haa);
      wr(8'hc7, 8'h12);
      wr(8'hc7, 8'h55);
      wr(8'hd8, 8'h22);
      rd(8'hd8, 8'hf3, 8'h60, "broken sequence");
      unlock();
      tick(13);
      wr(8'hd8, 8'h22);
      rd(8'hd8, 8'hf3, 8'h60, "window expired");
      unlock();
      wr(8'hf1, 8'h05);
      unlock();
      wr(8'h91, 8'h01);
      wr(8'h91, 8'h00);
      chk(romsel, 3'h5, "rom select");
      chk(bg, 1'b1, "bandgap kept");
      $display("test unlock done");
      bwarn <= 1'b1;
      ext <= 11'h7ff;
      // two sync stages, the flag and the registered vector, read one edge late
      tick(5);
      chk(vec, 8'h33, "warning vector");
      chk(ihigh, 1'b1, "warning level");
      bwarn <= 1'b0;
      tick(4);
      rd(8'hd8, 8'h30, 8'h30, "warning flag held");
      wr(8'hd8, 8'h20);
      tick(1);
      chk(vec, 8'h03, "warning cleared");
      wr(8'hd8, 8'h00);
      bwarn <= 1'b1;
      tick(4);
      bwarn <= 1'b0;
      chk(vec, 8'h03, "warning masked");
      rd(8'hd8, 8'h30, 8'h10, "flag without enable");
      wr(8'hd8, 8'h00);
      $display("test warning done");
      for (int k = 0; k < 11; k++) begin
         ext <= 11'h7ff << k;
         tick(2);
         chk(vec, k < 6 ? 8'h03 + 8 * k : 8'h0b + 8 * k, "natural order");
      end
      ext <= 11'h7ff;
      wr(8'hf3, 8'h04);
      tick(1);
      chk(vec, 8'h5b, "high level wins");
      chk(ihigh, 1'b1, "high level flag");
      wr(8'hf3, 8'h00);
      wr(8'hf2, 8'h40);
      tick(1);
      chk(vec, 8'h3b, "low reg high level");
      wr(8'hf2, 8'h00);
      ext <= 11'h0;
      $display("test priority done");
      wr(8'he8, 8'h10);
      for (int s = 0; s < 4; s++) begin
         unlock();
         wr(8'hd8, 8'h01);
         wr(8'h8e, {s[1:0], 6'h0});
         unlock();
         wr(8'hd8, 8'h03);
         count(1, n);
         chk(n, (32 << s) + 1, "dog irq period");
         count(2, n);
         chk(n, GAP - 1, "dog reset gap");
         tick(6);
      end
      wr(8'he8, 8'h00);
      unlock();
      wr(8'hd8, 8'h01);
      count(2, n);
      chk(n, 1000, "no reset when disabled");
      chk(vec, 8'h00, "dog irq masked");
      rd(8'hd8, 8'h0c, 8'h0c, "dog flags set");
      $display("test watchdog done");
      brst <= 1'b1;
      tick(5);
      chk(cpu_rst, 1'b1, "brownout reset");
      chk(osc_en, 1'b0, "brownout oscillator");
      brst <= 1'b0;
      count(0, n);
      chk(n, 20, "brownout restart");
      $display("test brownout done");
      conclude();
   end
endmodule // test_ssw_top
`default_nettype wire
